// file: common/ovf_pkg.sv
// Package with register map, field positions and reset values of the overflow flag block.
package ovf_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] STATUS_CONTROL_ADDR = 12'h000;
  localparam logic [11:0] IRQ_STATUS_ADDR     = 12'h004;
  localparam logic [11:0] IRQ_CLEAR_ADDR      = 12'h008;
  localparam logic [11:0] IRQ_ENABLE_ADDR     = 12'h00C;
  // ==========================================================================
  // Field positions
  localparam int OVERFLOW_FLAG_BIT = 7;
  localparam int OVF_IRQ_EN_BIT    = 6;
  localparam int EVT_OVERFLOW_BIT  = 0;
  localparam int EVT_CANCEL_BIT    = 1;
  localparam int EVT_WIDTH         = 2;
  // ==========================================================================
  // Reset values
  localparam logic [7:0]           STATUS_CONTROL_RESET = 8'h00;
  localparam logic [EVT_WIDTH-1:0] EVT_RESET            = 2'h0;
  localparam logic [31:0]          READ_ZERO            = 32'h0000_0000;
endpackage

// file: common/ovf_if.sv
// Interface carrying the flag state between the register slave and the flag logic.
`timescale 1ns/100ps
interface ovf_if;
  logic rd_sc;
  logic wr_sc;
  logic wr_flag_val;
  logic flag;
  logic cancel;
  modport regs (output rd_sc, output wr_sc, output wr_flag_val, input flag, input cancel);
  modport core (input rd_sc, input wr_sc, input wr_flag_val, output flag, output cancel);
endinterface

// file: core/ovf_flag.sv
// Overflow flag with read-then-write-zero clear sequence.
`timescale 1ns/100ps
module ovf_flag (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Counter event
  input  wire logic overflow,
  // Register side
  ovf_if.core       bus
);
  logic armed;
  logic next_armed;
  logic flag;
  logic next_flag;
  logic cancel;
  logic next_cancel;

  always_comb begin
    next_flag   = flag;
    next_armed  = armed;
    next_cancel = 1'b0;
    if (bus.rd_sc && flag) begin
      next_armed = 1'b1;
    end
    if (bus.wr_sc) begin
      if (!bus.wr_flag_val && armed) begin
        next_flag = 1'b0;
      end
      next_armed = 1'b0;
    end
    if (overflow) begin
      next_flag = 1'b1;
      if (armed || bus.rd_sc) begin
        next_armed = 1'b0;
      end
      next_cancel = bus.wr_sc && !bus.wr_flag_val && armed;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag   <= 1'b0;
      armed  <= 1'b0;
      cancel <= 1'b0;
    end else begin
      flag   <= next_flag;
      armed  <= next_armed;
      cancel <= next_cancel;
    end
  end

  assign bus.flag   = flag;
  assign bus.cancel = cancel;
endmodule

// file: core/ovf_top.sv
// Top of the timer overflow flag block with its APB register slave.
`timescale 1ns/100ps
// How it works
// - Flag at bit 7 sets whenever the counter passes the modulo value.
// - Flag clears only by reading it set, then writing zero to it.
// - Writing one to the flag leaves it unchanged.
// - An overflow between arming read and clearing write keeps flag and request.
// - Flag reads zero when no overflow happened since the last clear.
// - Interrupt request is high, one cycle later, while flag and enable bit 6 are set.
module ovf_top (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Counter event, one-cycle pulse on the same clock
  input  wire logic        overflow,
  // Interrupts
  output logic             ovf_irq,
  output logic             irq
);
  // ==========================================================================
  // Register access
  // Positions of the mapped registers in the one-hot select word.
  localparam int SEL_SC     = 0;
  localparam int SEL_STATUS = 1;
  localparam int SEL_CLEAR  = 2;
  localparam int SEL_ENABLE = 3;

  ovf_if link ();

  logic        acc;
  logic        take;
  logic        wr_take;
  logic        rd_take;
  logic [3:0]  sel;
  logic        hit;
  logic        wr_ctrl;
  logic        wr_clear;
  logic        wr_enable;
  logic [5:0]  sc_ctrl;
  logic [5:0]  next_sc_ctrl;
  logic        irq_en_bit;
  logic [1:0]  evt_status;
  logic [1:0]  next_evt_status;
  logic [1:0]  evt_enable;
  logic [1:0]  next_evt_enable;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_ovf_irq;
  logic        next_irq;

  // One-hot select of the mapped registers; all zero for an unmapped address.
  function automatic logic [3:0] reg_select(input logic [11:0] addr);
    logic [3:0] s;
    s             = 4'h0;
    s[SEL_SC]     = (addr == ovf_pkg::STATUS_CONTROL_ADDR);
    s[SEL_STATUS] = (addr == ovf_pkg::IRQ_STATUS_ADDR);
    s[SEL_CLEAR]  = (addr == ovf_pkg::IRQ_CLEAR_ADDR);
    s[SEL_ENABLE] = (addr == ovf_pkg::IRQ_ENABLE_ADDR);
    return s;
  endfunction

  // Places a two-bit register value in the low bits of a read word.
  function automatic logic [31:0] low_word(input logic [1:0] bits);
    return {30'h0000_0000, bits};
  endfunction

  // The access phase lasts two cycles, so an access is taken only at its first
  // edge. Otherwise a read could arm again after an overflow had disarmed it.
  assign acc       = psel && penable;
  assign take      = acc && !pready;
  assign wr_take   = take && pwrite;
  assign rd_take   = take && !pwrite;
  assign sel       = reg_select(paddr);
  assign hit       = |sel;
  assign wr_ctrl   = wr_take && sel[SEL_SC];
  assign wr_clear  = wr_take && sel[SEL_CLEAR];
  assign wr_enable = wr_take && sel[SEL_ENABLE];

  assign link.rd_sc       = rd_take && sel[SEL_SC];
  assign link.wr_sc       = wr_ctrl;
  assign link.wr_flag_val = pwdata[ovf_pkg::OVERFLOW_FLAG_BIT];
  assign irq_en_bit       = sc_ctrl[ovf_pkg::OVF_IRQ_EN_BIT-1];

  ovf_flag u_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .overflow(overflow),
    .bus     (link.core)
  );

  // ==========================================================================
  // Control bits of the status and control register

  // The control bits sit at register bits 6 to 1; bit 0 is not implemented.
  always_comb begin
    next_sc_ctrl = sc_ctrl;
    if (wr_ctrl) begin
      next_sc_ctrl = pwdata[6:1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_ctrl <= ovf_pkg::STATUS_CONTROL_RESET[6:1];
    end else begin
      sc_ctrl <= next_sc_ctrl;
    end
  end

  // ==========================================================================
  // Sticky event status and its enable

  always_comb begin
    next_evt_status = evt_status;
    next_evt_enable = evt_enable;
    if (wr_clear) begin
      next_evt_status = evt_status & ~pwdata[ovf_pkg::EVT_WIDTH-1:0];
    end
    if (wr_enable) begin
      next_evt_enable = pwdata[ovf_pkg::EVT_WIDTH-1:0];
    end
    // Events win over a clear in the same cycle.
    if (overflow) begin
      next_evt_status[ovf_pkg::EVT_OVERFLOW_BIT] = 1'b1;
    end
    if (link.cancel) begin
      next_evt_status[ovf_pkg::EVT_CANCEL_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= ovf_pkg::EVT_RESET;
      evt_enable <= ovf_pkg::EVT_RESET;
    end else begin
      evt_status <= next_evt_status;
      evt_enable <= next_evt_enable;
    end
  end

  // ==========================================================================
  // Bus response

  // Every taken access is answered one cycle later; unmapped ones are refused.
  always_comb begin
    next_pready  = take;
    next_pslverr = take && !hit;
    next_prdata  = ovf_pkg::READ_ZERO;
    if (rd_take) begin
      case (paddr)
        ovf_pkg::STATUS_CONTROL_ADDR: begin
          next_prdata = {24'h00_0000, link.flag, sc_ctrl, 1'b0};
        end
        ovf_pkg::IRQ_STATUS_ADDR: begin
          next_prdata = low_word(evt_status);
        end
        ovf_pkg::IRQ_ENABLE_ADDR: begin
          next_prdata = low_word(evt_enable);
        end
        default: begin
          next_prdata = ovf_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= ovf_pkg::READ_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================================
  // Interrupt outputs

  always_comb begin
    next_ovf_irq = link.flag && irq_en_bit;
    next_irq     = |(next_evt_status & next_evt_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_irq <= 1'b0;
      irq     <= 1'b0;
    end else begin
      ovf_irq <= next_ovf_irq;
      irq     <= next_irq;
    end
  end
endmodule

// file: bench/ovf_top_chk.sv
// Checker of the overflow flag block ports.
`timescale 1ns/100ps
module ovf_top_chk (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Counter event and interrupts
  input wire logic        overflow,
  input wire logic        ovf_irq,
  input wire logic        irq
);
  logic en;
  logic acc;
  logic seen;
  assign acc = psel && penable && !pready;
  // Remembers that the counter has overflowed since reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen <= 1'b0;
    else if (overflow) seen <= 1'b1;
  end
  // Shadow of the interrupt enable bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en <= 1'b0;
    else if (acc && pwrite && paddr == 12'h000) en <= pwdata[6];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_follows: assert property (acc |=> pready) else $error("ready missing");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_reads_zero: assert property (pslverr |-> pready && prdata == 0) else $error("bad error");
  a_sc_unused_zero: assert property (pready && !pslverr |-> prdata[31:8] == 0) else $error("high bits");
  a_ovf_sets_irq: assert property (overflow && en |=> ##1 ovf_irq) else $error("no request");
  a_irq_needs_en: assert property (ovf_irq |-> $past(en)) else $error("request unmasked");
  a_one_keeps: assert property (ovf_irq && acc && pwrite && paddr == 0
    && pwdata[7] && pwdata[6] |=> ##1 ovf_irq) else $error("write one cleared");
  a_cancel_keeps: assert property (acc && pwrite && paddr == 0 && overflow
    && !pwdata[7] && pwdata[6] |=> ##1 ovf_irq) else $error("clear not cancelled");
  a_flag_needs_ovf: assert property (pready && prdata[7] |-> seen) else $error("bad flag");
  a_reset_quiet: assert property ($rose(presetn) |-> !ovf_irq && !irq && !pready) else $error("rst");
  c_err: cover property (pslverr);
  c_ovf: cover property (overflow && en);
  c_clear: cover property ($fell(ovf_irq));
  c_cancel: cover property (acc && pwrite && paddr == 0 && !pwdata[7] && overflow);
endmodule
bind ovf_top ovf_top_chk u_ovf_top_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .overflow, .ovf_irq, .irq);

// file: bench/ovf_top_tb.sv
// Self-checking bench of the overflow flag block.
`timescale 1ns/100ps
module ovf_top_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, overflow = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, ovf_irq, irq, err;
  int          num_errors = 0, samples_checked = 0, flag = 0, arm = 0, ctl = 0, ev = 0, ien = 0;
  ovf_top u_ovf_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .overflow, .ovf_irq, .irq);
  initial forever #25 pclk = ~pclk;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================================================
  // One APB access with the model update and comparisons.
  task automatic acc(logic w, logic [11:0] a, logic [31:0] d, logic o = 1'b0);
    logic [31:0] e;
    logic        cx;
    e = 0;
    cx = o && w && a == 0 && arm != 0 && !d[7];
    if (a == 0 && w) begin
      ctl = d[6:1];
      if (arm && !d[7]) flag = 0;
      arm = 0;
    end
    if (a == 0 && !w) e = flag << 7 | ctl << 1;
    if (a == 0 && !w) arm = flag;
    if (a == 12'h004 && !w) e = ev;
    if (a == 12'h00c && !w) e = ien;
    if (a == 12'h00c && w) ien = d[1:0];
    if (a == 12'h008 && w) ev = ev & ~d[1:0];
    // An overflow in the taken cycle wins over a clear and disarms.
    if (o) begin
      flag = 1;
      arm = 0;
      ev = ev | 1;
    end
    if (cx) ev = ev | 2;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    overflow <= o;
    @(posedge pclk);
    overflow <= 0;
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    chk(rd, e);
    chk(err, a > 12'h00c);
    repeat (2) @(posedge pclk);
    chk(ovf_irq, flag != 0 && ctl[5]);
    chk(irq, (ev & ien) != 0);
  endtask
  task automatic rst;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    flag = 0;
    arm = 0;
    ctl = 0;
    ev = 0;
    ien = 0;
  endtask
  task automatic ovf;
    overflow <= 1;
    @(posedge pclk);
    overflow <= 0;
    flag = 1;
    arm = 0;
    ev = ev | 1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(64388));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    acc(0, 0, 0);
    acc(1, 0, $urandom & 32'h7e | 32'h40);
    ovf();
    acc(1, 0, 32'h40);
    acc(0, 0, 0);
    acc(1, 0, 32'hc0);
    acc(0, 0, 0);
    ovf();
    acc(1, 0, 32'h40);
    acc(0, 0, 0);
    acc(1, 0, $urandom & 32'h7e | 32'h40);
    acc(0, 0, 0);
    $display("test flag sequence done");
    acc(0, 12'h004, 0);
    acc(1, 12'h00c, 1);
    acc(1, 12'h008, 1);
    ovf();
    acc(1, 12'h00c, 0);
    acc(0, 12'h00c, 0);
    acc(0, 12'h010, 0);
    $display("test event registers done");
    acc(0, 0, 0);
    acc(1, 0, 32'h40, 1);
    acc(0, 12'h004, 0);
    acc(1, 12'h00c, 2);
    acc(1, 0, 32'h80);
    acc(0, 0, 0);
    $display("test cancelled clear done");
    rst();
    acc(0, 0, 0);
    acc(0, 12'h004, 0);
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule
